// file: verilog/l2cc_control.sv
// secondary-cache control register, strap capture and cycle decisions
`timescale 1ns/100ps
`default_nettype none
`include "l2cc_consts.svh"

// Behaviour
// - eight-bit control register, reset value straps in top nibble, 0010 below.
// - after hard reset, bits 7:4 load inverted from host address lines 31:28.
// - size field takes inverted lines 31:30 at processor reset rise; writable later.
// - size codes: none, 256K, 512K, reserved.
// - size zero keeps cache off; on only with size set and first-level enable.
// - SRAM kind field takes inverted lines 29:28 at processor reset rise.
// - kind codes: pipelined burst, reserved, asynchronous, two pipelined banks.
// - 512K pipelined burst delays next-address by one clock on burst reads.
// - next-address disable set means next-address request not asserted once the bit has been set for two clocks.
// - force-miss disables hits; every lookup misses while cache enabled.
// - populated, first-level off, force-miss: each read invalidates its tag.
// - flush by force-miss reads of every line; modified lines written back only while first-level enable is set.
// - first-level enable asserts cacheable indication on cacheable cycles.
// - first-level off keeps cacheable indication negated and blocks fills.
// - first-level enable with force-miss also forces writes to miss.
module l2cc_control (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    processorReset,
  input  wire logic [3:0]              hostAddrHigh,
  input  wire logic [7:0]              cfgAddr,
  input  wire logic                    cfgWrite,
  input  wire logic                    cfgRead,
  input  wire logic [7:0]              cfgWdata,
  output logic      [7:0]              cfgRdata_reg,
  input  wire logic                    cycStart,
  input  wire logic                    cycWrite,
  input  wire logic                    cycCacheable,
  input  wire logic                    cycBurst,
  input  wire logic [`L2CC_LINE_W-1:0] cycLine,
  input  wire logic                    tagHit,
  output logic                         cacheableIndication_n_reg,
  output logic                         nextAddressRequest_n_reg,
  output logic                         l2Enabled_reg,
  output logic                         l2HitPulse_reg,
  output logic                         lineFill_reg,
  output logic                         tagInvalidate_reg,
  output logic                         writeBack_reg
);

  logic [7:0]                  l2CacheControl_reg;
  logic                        strapPending_reg;
  logic                        procResetPrev_reg;
  logic                        strapLoad;
  logic                        ctrlHit;
  l2cc_pkg::l2cc_size_t        l2SizeSelect;
  l2cc_pkg::l2cc_kind_t        l2SramKind;
  logic                        nextAddressDisable;
  logic                        forceMiss;
  logic                        firstLevelEnable;
  logic                        populated;
  logic                        l2On;
  logic                        pipelinedKind;
  logic                        nextAddrDelay;
  logic                        reqValid_reg;
  logic                        reqWrite_reg;
  logic                        reqCacheable_reg;
  logic                        reqBurst_reg;
  logic                        reqTagHit_reg;
  logic [`L2CC_LINE_W-1:0]     reqLine_reg;
  l2cc_pkg::l2cc_status_t      statusRd;
  logic                        lineValid;
  logic                        lineDirty;
  logic                        readReq;
  logic                        hit;
  logic                        doFill;
  logic                        doWriteBack;
  logic                        doInvalidate;
  logic                        statusWrEn;
  l2cc_pkg::l2cc_status_t      statusWrData;
  logic                        nextAddrCause;
  logic                        nextAddrPend_reg;

  //////////////////////////////////////////////////////////////////////////////
  // control register with strap capture
  assign strapLoad = strapPending_reg || (processorReset && !procResetPrev_reg);
  assign ctrlHit   = (cfgAddr == `L2CC_CTRL_OFFSET);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strapPending_reg  <= 1'b1;
      procResetPrev_reg <= 1'b0;
    end
    else
    begin
      strapPending_reg  <= 1'b0;
      procResetPrev_reg <= processorReset;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      l2CacheControl_reg <= {`L2CC_STRAP_CLEAR, `L2CC_LOW_DEFAULT};
    else if (strapLoad)
      l2CacheControl_reg <= {~hostAddrHigh, `L2CC_LOW_DEFAULT};
    else if (cfgWrite && ctrlHit)
      l2CacheControl_reg <= cfgWdata & `L2CC_WRITE_MASK;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cfgRdata_reg <= `L2CC_READ_IDLE;
    else if (cfgRead && ctrlHit)
      cfgRdata_reg <= l2CacheControl_reg & `L2CC_WRITE_MASK;
    else
      cfgRdata_reg <= `L2CC_READ_IDLE;
  end

  //////////////////////////////////////////////////////////////////////////////
  // field decode
  assign l2SizeSelect = l2cc_pkg::l2cc_size_t'(l2CacheControl_reg[`L2CC_SIZE_HI:`L2CC_SIZE_LO]);
  assign l2SramKind   = l2cc_pkg::l2cc_kind_t'(l2CacheControl_reg[`L2CC_KIND_HI:`L2CC_KIND_LO]);
  assign nextAddressDisable = l2CacheControl_reg[`L2CC_NEXT_ADDR_OFF_BIT];
  assign forceMiss          = l2CacheControl_reg[`L2CC_FMI_BIT];
  assign firstLevelEnable   = l2CacheControl_reg[`L2CC_FIRST_LEVEL_BIT];

  assign populated = (l2SizeSelect == l2cc_pkg::L2CC_SIZE_256K) ||
                     (l2SizeSelect == l2cc_pkg::L2CC_SIZE_512K);
  assign l2On      = populated && firstLevelEnable;
  assign pipelinedKind = (l2SramKind == l2cc_pkg::L2CC_KIND_PBURST) ||
                         (l2SramKind == l2cc_pkg::L2CC_KIND_PBURST2);
  assign nextAddrDelay = pipelinedKind && (l2SizeSelect == l2cc_pkg::L2CC_SIZE_512K);

  //////////////////////////////////////////////////////////////////////////////
  // request stage, aligned with the status read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reqValid_reg     <= 1'b0;
      reqWrite_reg     <= 1'b0;
      reqCacheable_reg <= 1'b0;
      reqBurst_reg     <= 1'b0;
      reqTagHit_reg    <= 1'b0;
      reqLine_reg      <= '0;
    end
    else
    begin
      reqValid_reg     <= cycStart;
      reqWrite_reg     <= cycWrite;
      reqCacheable_reg <= cycCacheable;
      reqBurst_reg     <= cycBurst;
      reqTagHit_reg    <= tagHit;
      reqLine_reg      <= cycLine;
    end
  end

  l2cc_line_status u_status (
    .clk    (clk),
    .rst_n  (rst_n),
    .rdAddr (cycLine),
    .rdData (statusRd),
    .wrEn   (statusWrEn),
    .wrAddr (reqLine_reg),
    .wrData (statusWrData)
  );

  //////////////////////////////////////////////////////////////////////////////
  // cycle decisions
  assign lineValid   = statusRd[`L2CC_ST_VALID];
  assign lineDirty   = statusRd[`L2CC_ST_DIRTY];
  assign readReq     = reqValid_reg && !reqWrite_reg;
  assign hit         = reqValid_reg && l2On && !forceMiss && reqTagHit_reg &&
                       lineValid;
  assign doFill      = readReq && l2On && !forceMiss && reqCacheable_reg && !hit;
  assign doWriteBack = readReq && l2On && !hit && lineValid && lineDirty &&
                       (forceMiss || doFill);
  assign doInvalidate = readReq && populated && forceMiss;
  assign nextAddrCause = readReq && reqBurst_reg && hit && !nextAddressDisable &&
                         pipelinedKind;

  always_comb
  begin
    statusWrEn   = 1'b0;
    statusWrData = `L2CC_ST_EMPTY;
    if (doInvalidate)
    begin
      statusWrEn   = 1'b1;
      statusWrData = `L2CC_ST_EMPTY;
    end
    else if (doFill)
    begin
      statusWrEn   = 1'b1;
      statusWrData = `L2CC_ST_CLEAN;
    end
    else if (hit && reqWrite_reg)
    begin
      statusWrEn   = 1'b1;
      statusWrData = `L2CC_ST_MODIFIED;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nextAddrPend_reg         <= 1'b0;
      nextAddressRequest_n_reg <= 1'b1;
    end
    else
    begin
      nextAddrPend_reg         <= nextAddrCause && nextAddrDelay;
      nextAddressRequest_n_reg <= !((nextAddrCause && !nextAddrDelay) ||
                                    nextAddrPend_reg);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cacheableIndication_n_reg <= 1'b1;
      l2Enabled_reg             <= 1'b0;
      l2HitPulse_reg            <= 1'b0;
      lineFill_reg              <= 1'b0;
      tagInvalidate_reg         <= 1'b0;
      writeBack_reg             <= 1'b0;
    end
    else
    begin
      cacheableIndication_n_reg <= !(reqValid_reg && firstLevelEnable &&
                                     reqCacheable_reg);
      l2Enabled_reg             <= l2On;
      l2HitPulse_reg            <= hit;
      lineFill_reg              <= doFill;
      tagInvalidate_reg         <= doInvalidate;
      writeBack_reg             <= doWriteBack;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_cacheable_cycle;
    cycStart && cycCacheable && firstLevelEnable ##1 firstLevelEnable;
  endsequence

  sequence s_delayed_next_addr;
    nextAddressRequest_n_reg ##1 !nextAddressRequest_n_reg;
  endsequence

  chk_reserved_read: assert property (
    cfgRead && ctrlHit |=> cfgRdata_reg[`L2CC_RSVD_BIT] == 1'b0)
    else $error("reserved bit read back as one");

  chk_strap_capture: assert property (
    processorReset && !procResetPrev_reg && !strapPending_reg |=>
      l2CacheControl_reg[`L2CC_STRAP_HI:`L2CC_STRAP_LO] == ~$past(hostAddrHigh))
    else $error("strap nibble not captured inverted");

  chk_next_addr_off: assert property (
    nextAddressDisable && $past(nextAddressDisable) && $past(nextAddressDisable, 2)
      |-> nextAddressRequest_n_reg)
    else $error("next-address asserted while disabled");

  chk_cacheable_negated: assert property (
    $past(!firstLevelEnable) |-> cacheableIndication_n_reg)
    else $error("cacheable indication with first level off");

  chk_cacheable_asserted: assert property (
    s_cacheable_cycle |=> !cacheableIndication_n_reg)
    else $error("cacheable indication missing");

  chk_next_addr_delay: assert property (
    nextAddrCause && nextAddrDelay && !nextAddrPend_reg |-> ##1 s_delayed_next_addr)
    else $error("next-address not delayed one clock");

  chk_size_off: assert property (
    !populated |=> !l2Enabled_reg && !lineFill_reg)
    else $error("cache active without size");

  chk_force_nohit: assert property (
    forceMiss && reqValid_reg |=> !l2HitPulse_reg)
    else $error("hit reported under force-miss");

  chk_tag_invalidate: assert property (
    readReq && populated && !firstLevelEnable && forceMiss |=> tagInvalidate_reg)
    else $error("read did not invalidate tag");

  chk_write_miss: assert property (
    reqValid_reg && reqWrite_reg && firstLevelEnable && forceMiss |-> !statusWrEn)
    else $error("write updated cache under force-miss");

  chk_flush_writeback: assert property (
    readReq && l2On && forceMiss && lineValid && lineDirty |=>
      writeBack_reg && tagInvalidate_reg)
    else $error("flush read missed write-back");

endmodule : l2cc_control
`default_nettype wire

// file: pkg/l2cc_consts.svh
// constants for the secondary-cache control register and its cache logic
`ifndef L2CC_CONSTS_SVH
`define L2CC_CONSTS_SVH

`define L2CC_CTRL_OFFSET   8'h52
`define L2CC_LOW_DEFAULT   4'h2
`define L2CC_STRAP_CLEAR   4'h0
`define L2CC_WRITE_MASK    8'hFB
`define L2CC_READ_IDLE     8'h00

`define L2CC_SIZE_HI       7
`define L2CC_SIZE_LO       6
`define L2CC_KIND_HI       5
`define L2CC_KIND_LO       4
`define L2CC_STRAP_HI      7
`define L2CC_STRAP_LO      4
`define L2CC_NEXT_ADDR_OFF_BIT 3
`define L2CC_RSVD_BIT      2
`define L2CC_FMI_BIT       1
`define L2CC_FIRST_LEVEL_BIT 0

`define L2CC_LINE_W        4
`define L2CC_LINES         16
`define L2CC_ST_VALID      0
`define L2CC_ST_DIRTY      1
`define L2CC_ST_CLEAN      2'h1
`define L2CC_ST_MODIFIED   2'h3
`define L2CC_ST_EMPTY      2'h0

`endif

// file: pkg/l2cc_pkg.sv
// types for the secondary-cache control block
`default_nettype none
package l2cc_pkg;

  typedef enum logic [1:0] {
    L2CC_SIZE_NONE = 2'h0,
    L2CC_SIZE_256K = 2'h1,
    L2CC_SIZE_512K = 2'h2,
    L2CC_SIZE_RSVD = 2'h3
  } l2cc_size_t;

  typedef enum logic [1:0] {
    L2CC_KIND_PBURST  = 2'h0,
    L2CC_KIND_RSVD    = 2'h1,
    L2CC_KIND_ASYNC   = 2'h2,
    L2CC_KIND_PBURST2 = 2'h3
  } l2cc_kind_t;

  typedef logic [1:0] l2cc_status_t;

endpackage : l2cc_pkg
`default_nettype wire

// file: verilog/l2cc_line_status.sv
// line status memory: valid and modified bit per cache line, registered read
`timescale 1ns/100ps
`default_nettype none
`include "l2cc_consts.svh"

module l2cc_line_status (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [`L2CC_LINE_W-1:0]   rdAddr,
  output var  l2cc_pkg::l2cc_status_t    rdData,
  input  wire logic                      wrEn,
  input  wire logic [`L2CC_LINE_W-1:0]   wrAddr,
  input  wire l2cc_pkg::l2cc_status_t    wrData
);

  l2cc_pkg::l2cc_status_t entry_reg [`L2CC_LINES];

  //////////////////////////////////////////////////////////////////////////////
  // one status entry per line, cleared at reset
  genvar gi;
  generate
    for (gi = 0; gi < `L2CC_LINES; gi++)
    begin : g_entry
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          entry_reg[gi] <= `L2CC_ST_EMPTY;
        else if (wrEn && (wrAddr == (`L2CC_LINE_W)'(gi)))
          entry_reg[gi] <= wrData;
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // registered read port
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdData <= `L2CC_ST_EMPTY;
    else
      rdData <= entry_reg[rdAddr];
  end

endmodule : l2cc_line_status
`default_nettype wire

// file: tb/l2cc_host_model.sv
// host processor and tag side model: issues processor cycles with their tag answer
`timescale 1ns/100ps
`default_nettype none

module l2cc_host_model (
  input  wire logic       clk,
  output var  logic       cycStart,
  output var  logic       cycWrite,
  output var  logic       cycCacheable,
  output var  logic       cycBurst,
  output var  logic [3:0] cycLine,
  output var  logic       tagHit
);
  initial
  begin
    cycStart     = 1'h0;
    cycWrite     = 1'h0;
    cycCacheable = 1'h0;
    cycBurst     = 1'h0;
    cycLine      = 4'h0;
    tagHit       = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle start; qualifiers flip to their inverse once taken, never left stale
  task automatic issue(input logic w, input logic c, input logic b,
                       input logic [3:0] ln, input logic h);
    @(posedge clk);
    cycStart     <= 1'h1;
    cycWrite     <= w;
    cycCacheable <= c;
    cycBurst     <= b;
    cycLine      <= ln;
    tagHit       <= h;
    @(posedge clk);
    cycStart     <= 1'h0;
    cycWrite     <= ~w;
    cycCacheable <= ~c;
    cycBurst     <= ~b;
    cycLine      <= ~ln;
    tagHit       <= ~h;
  endtask : issue
endmodule : l2cc_host_model
`default_nettype wire

// file: tb/l2cc_control_tb.sv
// self-checking bench for the secondary-cache control register
`timescale 1ns/100ps
`default_nettype none
`include "l2cc_consts.svh"

module l2cc_control_tb;
  logic       clk, rst_n, processorReset, cfgWrite, cfgRead;
  logic [3:0] hostAddrHigh;
  logic [7:0] cfgAddr, cfgWdata, cfgRdata_reg, rd;
  logic       cycStart, cycWrite, cycCacheable, cycBurst, tagHit;
  logic [3:0] cycLine;
  logic       cacheN, nextAddrN, l2En, hitP, fillP, invP, wbP;
  logic       cache2, nextAddr2, nextAddr3, hit2, fill2, inv2, wb2;
  int         failures, num_checks, cycles;

  l2cc_control u_l2cc_control (.clk(clk), .rst_n(rst_n), .processorReset(processorReset),
    .hostAddrHigh(hostAddrHigh), .cfgAddr(cfgAddr), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
    .cfgWdata(cfgWdata), .cfgRdata_reg(cfgRdata_reg), .cycStart(cycStart),
    .cycWrite(cycWrite), .cycCacheable(cycCacheable), .cycBurst(cycBurst),
    .cycLine(cycLine), .tagHit(tagHit), .cacheableIndication_n_reg(cacheN),
    .nextAddressRequest_n_reg(nextAddrN), .l2Enabled_reg(l2En), .l2HitPulse_reg(hitP),
    .lineFill_reg(fillP), .tagInvalidate_reg(invP), .writeBack_reg(wbP));

  l2cc_host_model u_l2cc_host_model (.clk(clk), .cycStart(cycStart), .cycWrite(cycWrite),
    .cycCacheable(cycCacheable), .cycBurst(cycBurst), .cycLine(cycLine), .tagHit(tagHit));

  ////////////////////////////////////////////////////////////////////////////////
  initial clk = 1'h0;
  always #12.5 clk = ~clk;

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      failures++;
      finish_test();
    end
  end

  task automatic finish_test;
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check8

  task automatic check1(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask : check1

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfgAddr  <= a;
    cfgWdata <= d;
    cfgWrite <= 1'h1;
    @(posedge clk);
    cfgWrite <= 1'h0;
  endtask : cfg_write

  task automatic cfg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    cfgAddr <= a;
    cfgRead <= 1'h1;
    @(posedge clk);
    cfgRead <= 1'h0;
    @(negedge clk);
    d = cfgRdata_reg;
  endtask : cfg_read

  // answers land in the second and third cycle after the start cycle
  task automatic cyc(input logic w, input logic c, input logic b,
                     input logic [3:0] ln, input logic h);
    u_l2cc_host_model.issue(w, c, b, ln, h);
    @(posedge clk);
    @(negedge clk);
    cache2 = cacheN;
    nextAddr2 = nextAddrN;
    hit2 = hitP;
    fill2 = fillP;
    inv2 = invP;
    wb2 = wbP;
    @(posedge clk);
    @(negedge clk);
    nextAddr3 = nextAddrN;
  endtask : cyc

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    failures = 0;
    num_checks = 0;
    cycles = 0;
    rst_n = 1'h0;
    processorReset = 1'h0;
    hostAddrHigh = 4'h6;
    cfgAddr = 8'h00;
    cfgWrite = 1'h0;
    cfgRead = 1'h0;
    cfgWdata = 8'h00;
    repeat (2) @(posedge clk);
    check1("cacheable idle", 1'h1, cacheN);
    check1("next address idle", 1'h1, nextAddrN);
    rst_n <= 1'h1;
    cfg_read(`L2CC_CTRL_OFFSET, rd);
    check8("strap value", 8'h92, rd);
    check1("l2 enabled", 1'h0, l2En);
    @(posedge clk);
    processorReset <= 1'h1;
    hostAddrHigh <= 4'hA;
    repeat (2) @(posedge clk);
    processorReset <= 1'h0;
    cfg_read(`L2CC_CTRL_OFFSET, rd);
    check8("strap reload", 8'h52, rd);
    cfg_write(`L2CC_CTRL_OFFSET, 8'hFF);
    cfg_write(8'h53, 8'h00);
    cfg_read(`L2CC_CTRL_OFFSET, rd);
    check8("reserved bit", 8'hFB, rd);
    cfg_read(8'h53, rd);
    check8("other address", 8'h00, rd);
    for (int s = 0; s < 4; s++)
    begin
      cfg_write(`L2CC_CTRL_OFFSET, {s[1:0], 6'h01});
      cfg_read(`L2CC_CTRL_OFFSET, rd);
      check8("size field", {s[1:0], 6'h01}, rd);
      check1("l2 enabled", logic'(s == 1 || s == 2), l2En);
    end
    cfg_write(`L2CC_CTRL_OFFSET, 8'h41);
    cyc(1'h0, 1'h1, 1'h0, 4'h3, 1'h0);
    check1("fill", 1'h1, fill2);
    check1("cacheable", 1'h0, cache2);
    cyc(1'h1, 1'h1, 1'h0, 4'h3, 1'h1);
    check1("write hit", 1'h1, hit2);
    // no sdram main memory here, so the asynchronous kind may be chosen
    for (int k = 0; k < 4; k++)
    begin
      cfg_write(`L2CC_CTRL_OFFSET, {2'h1, k[1:0], 4'h1});
      cyc(1'h0, 1'h1, 1'h1, 4'h3, 1'h1);
      check1("next address", logic'(k == 1 || k == 2), nextAddr2);
    end
    cfg_write(`L2CC_CTRL_OFFSET, 8'h49);
    cyc(1'h0, 1'h1, 1'h1, 4'h3, 1'h1);
    check1("read hit", 1'h1, hit2);
    check1("next address disabled", 1'h1, nextAddr2 & nextAddr3);
    cfg_write(`L2CC_CTRL_OFFSET, 8'h81);
    cyc(1'h0, 1'h1, 1'h1, 4'h3, 1'h1);
    check1("next address early", 1'h1, nextAddr2);
    check1("next address delayed", 1'h0, nextAddr3);
    cfg_write(`L2CC_CTRL_OFFSET, 8'h43);
    cyc(1'h1, 1'h1, 1'h0, 4'h3, 1'h1);
    check1("forced write", 1'h0, hit2);
    cyc(1'h0, 1'h1, 1'h0, 4'h3, 1'h1);
    check1("forced read", 1'h0, hit2 | fill2);
    check1("flush", 1'h1, wb2);
    cfg_write(`L2CC_CTRL_OFFSET, 8'h40);
    cyc(1'h0, 1'h1, 1'h0, 4'h5, 1'h0);
    check1("cacheable off", 1'h1, cache2);
    check1("no fill", 1'h0, fill2);
    check1("l2 enabled", 1'h0, l2En);
    cfg_write(`L2CC_CTRL_OFFSET, 8'h42);
    cyc(1'h0, 1'h1, 1'h0, 4'h5, 1'h0);
    check1("invalidate", 1'h1, inv2);
    cfg_write(`L2CC_CTRL_OFFSET, 8'h03);
    cyc(1'h0, 1'h1, 1'h0, 4'h5, 1'h0);
    check1("no invalidate", 1'h0, inv2);
    check1("l2 enabled", 1'h0, l2En);
    // hard reset in mid-run reloads the strap nibble
    @(posedge clk);
    hostAddrHigh <= 4'h3;
    rst_n <= 1'h0;
    @(posedge clk);
    rst_n <= 1'h1;
    cfg_read(`L2CC_CTRL_OFFSET, rd);
    check8("hard reset straps", 8'hC2, rd);
    check1("l2 enabled", 1'h0, l2En);
    finish_test();
  end
endmodule : l2cc_control_tb
`default_nettype wire
